// ===== aef_cfg.svh
// Constants for the axis enable and feedback block
`ifndef AEF_CFG_SVH
`define AEF_CFG_SVH
`define AEF_ADR_CTRL    8'h00
`define AEF_ADR_ERRLIM  8'h04
`define AEF_ADR_CMDPOS  8'h08
`define AEF_ADR_POS     8'h0c
`define AEF_ADR_HSEL    8'h10
`define AEF_ADR_STATUS  8'h14
`define AEF_ADR_IRQST   8'h18
`define AEF_ADR_IRQMSK  8'h1c
`define AEF_ADR_WDLIM   8'h20
`define AEF_ADR_CMD     8'h24
`define AEF_ADR_PHASE   8'h28
`define AEF_CTRL_OOE     0
`define AEF_CTRL_STEPDIR 1
`define AEF_CTRL_AMPINV  2
`define AEF_CMD_MOFF     0
`define AEF_CMD_MON      1
`define AEF_CMD_KICK     2
`define AEF_IRQ_WDOG     0
`define AEF_IRQ_ERR      1
`define AEF_IRQ_INDEX    2
`define AEF_ST_AMPON     0
`define AEF_ST_WDEXP     1
`define AEF_ST_OVER      2
`define AEF_ST_HALL      4
`define AEF_ST_PHASE     8
`define AEF_ST_PHOK      11
`define AEF_ST_HSELOK    12
`define AEF_ERRLIM_RST   32'h000007d0
`define AEF_WDLIM_RST    32'h00000000
`define AEF_HSEL_RST     7'h00
`define AEF_HALL_W       7'h03
`define AEF_GEN_LO       7'h01
`define AEF_GEN_HI       7'h08
`define AEF_EXT_LO       7'h11
`define AEF_EXT_HI       7'h50
`define AEF_AUX_LO       7'h51
`define AEF_AUX_HI       7'h60
`define AEF_HALL_BAD     3'h7
`endif

// ===== aef_pkg.sv
// Types shared by the axis enable and feedback block
package aef_pkg;
    typedef logic [31:0] aef_word_t;
    typedef logic [2:0]  aef_irq_t;
    typedef enum logic {AEF_QUAD = 1'b0, AEF_STEPDIR = 1'b1} aef_enc_mode_t;
endpackage

// ===== aef_axis.sv
// One axis: amplifier enable, encoder counter, Hall phase, Wishbone regs
`include "aef_cfg.svh"
module aef_axis (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire aef_pkg::aef_word_t dat_i,
    output logic                   ack_o,
    output aef_pkg::aef_word_t     dat_o,
    // Encoder and digital input pins
    input  wire logic              quad_channel_a_i,
    input  wire logic              quad_channel_b_i,
    input  wire logic              index_i,
    input  wire logic [95:0]       dig_in_i,
    // Amplifier and interrupt
    output logic                   amp_enable_out_o,
    output logic                   irq_o
);
    import aef_pkg::*;

    function automatic aef_word_t wmerge(aef_word_t old, aef_word_t nw,
                                         logic [3:0] sel);
        aef_word_t r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [2:0] hall_sector(logic [2:0] h);
        logic [2:0] s;
        s = `AEF_HALL_BAD;
        unique case (h)
            3'h1: s = 3'h0;
            3'h3: s = 3'h1;
            3'h2: s = 3'h2;
            3'h6: s = 3'h3;
            3'h4: s = 3'h4;
            3'h5: s = 3'h5;
            default: s = `AEF_HALL_BAD;
        endcase
        return s;
    endfunction

    function automatic logic in_range(logic [6:0] s, logic [6:0] lo,
                                      logic [6:0] hi);
        // One bit wider so a start near the top cannot wrap below hi
        return (s >= lo) &&
               ({1'b0, s} + {1'b0, `AEF_HALL_W} - 8'h01 <= {1'b0, hi});
    endfunction

    // Registers
    logic [2:0]   ctrl_ff, nxt_ctrl;
    aef_word_t    errlim_ff, nxt_errlim;
    aef_word_t    cmdpos_ff, nxt_cmdpos;
    aef_word_t    pos_ff, nxt_pos;
    logic [6:0]   hsel_ff, nxt_hsel;
    aef_word_t    wdlim_ff, nxt_wdlim;
    aef_word_t    wdcnt_ff, nxt_wdcnt;
    logic         amp_on_ff, nxt_amp_on;
    logic         amp_out_ff, nxt_amp_out;
    aef_irq_t     stat_ff, nxt_stat;
    aef_irq_t     mask_ff, nxt_mask;
    logic [2:0]   phase_ff, nxt_phase;
    logic         phase_ok_ff, nxt_phase_ok;
    logic         ack_ff, nxt_ack;
    aef_word_t    dat_ff, nxt_dat;
    // Synchronisers: stage one feeds stage two only
    logic [2:0]   enc_s1_ff, enc_s2_ff, enc_prev_ff;
    logic [95:0]  din_s1_ff, din_s2_ff;

    // Decoded bus access
    logic         acc, wr, rd;
    logic         wr_ctrl, wr_pos, wr_cmd, rd_irqst;
    logic         mon_cmd, moff_cmd, kick;
    // Encoder and supervision terms
    logic         a_now, b_now, a_old, b_old, idx_rise;
    logic         a_edge, b_edge;
    aef_enc_mode_t mode;
    logic signed [31:0] perr;
    aef_word_t    perr_mag;
    logic         over, err_trip, wd_on, wd_exp, wd_trip;
    logic [2:0]   hall_raw, sector;
    logic         hsel_ok;
    aef_irq_t     events;
    aef_word_t    status, rdata;

    assign acc      = cyc_i && stb_i && !ack_ff;
    assign wr       = acc && we_i;
    assign rd       = acc && !we_i;
    assign wr_ctrl  = wr && (adr_i == `AEF_ADR_CTRL);
    assign wr_pos   = wr && (adr_i == `AEF_ADR_POS) && (sel_i != 4'h0);
    assign wr_cmd   = wr && (adr_i == `AEF_ADR_CMD) && sel_i[0];
    assign rd_irqst = rd && (adr_i == `AEF_ADR_IRQST);
    assign moff_cmd = wr_cmd && dat_i[`AEF_CMD_MOFF];
    assign mon_cmd  = wr_cmd && dat_i[`AEF_CMD_MON];
    assign kick     = wr_cmd && dat_i[`AEF_CMD_KICK];

    assign a_now    = enc_s2_ff[0];
    assign b_now    = enc_s2_ff[1];
    assign a_old    = enc_prev_ff[0];
    assign b_old    = enc_prev_ff[1];
    assign a_edge   = a_now ^ a_old;
    assign b_edge   = b_now ^ b_old;
    assign idx_rise = enc_s2_ff[2] && !enc_prev_ff[2];
    assign mode     = aef_enc_mode_t'(ctrl_ff[`AEF_CTRL_STEPDIR]);

    // Magnitude check; a limit of zero trips on any error
    assign perr     = signed'(cmdpos_ff - pos_ff);
    assign perr_mag = perr[31] ? 32'(-perr) : 32'(perr);
    assign over     = perr_mag > errlim_ff;
    assign err_trip = ctrl_ff[`AEF_CTRL_OOE] && amp_on_ff && over;

    // Watchdog counts cycles between kicks; a limit of zero turns it off
    assign wd_on    = wdlim_ff != 32'h0;
    assign wd_exp   = wd_on && (wdcnt_ff == wdlim_ff);
    assign wd_trip  = wd_on && !kick && (wdcnt_ff == 32'(wdlim_ff - 32'h1));

    assign hsel_ok  = in_range(hsel_ff, `AEF_GEN_LO, `AEF_GEN_HI) ||
                      in_range(hsel_ff, `AEF_EXT_LO, `AEF_EXT_HI) ||
                      in_range(hsel_ff, `AEF_AUX_LO, `AEF_AUX_HI);
    // Line n sits at bit n-1; three consecutive lines form the Hall word
    assign hall_raw = hsel_ok ? 3'(din_s2_ff >> 7'(hsel_ff - 7'h01))
                              : 3'h0;
    assign sector   = hall_sector(hall_raw);

    always_comb
    begin
        events = '0;
        events[`AEF_IRQ_WDOG]  = wd_trip;
        events[`AEF_IRQ_ERR]   = err_trip;
        events[`AEF_IRQ_INDEX] = idx_rise;
        status = '0;
        status[`AEF_ST_AMPON]          = amp_on_ff;
        status[`AEF_ST_WDEXP]          = wd_exp;
        status[`AEF_ST_OVER]           = over;
        status[`AEF_ST_HALL +: 3]      = hall_raw;
        status[`AEF_ST_PHASE +: 3]     = phase_ff;
        status[`AEF_ST_PHOK]           = phase_ok_ff;
        status[`AEF_ST_HSELOK]         = hsel_ok;
        unique case (adr_i)
            `AEF_ADR_CTRL:   rdata = {29'h0, ctrl_ff};
            `AEF_ADR_ERRLIM: rdata = errlim_ff;
            `AEF_ADR_CMDPOS: rdata = cmdpos_ff;
            `AEF_ADR_POS:    rdata = pos_ff;
            `AEF_ADR_HSEL:   rdata = {25'h0, hsel_ff};
            `AEF_ADR_STATUS: rdata = status;
            `AEF_ADR_IRQST:  rdata = {29'h0, stat_ff};
            `AEF_ADR_IRQMSK: rdata = {29'h0, mask_ff};
            `AEF_ADR_WDLIM:  rdata = wdlim_ff;
            `AEF_ADR_PHASE:  rdata = {29'h0, phase_ff};
            default:         rdata = 32'h0;
        endcase
    end

    // Bus and configuration registers
    always_comb
    begin
        nxt_ack    = acc;
        nxt_dat    = rd ? rdata : dat_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_errlim = errlim_ff;
        nxt_cmdpos = cmdpos_ff;
        nxt_hsel   = hsel_ff;
        nxt_mask   = mask_ff;
        nxt_wdlim  = wdlim_ff;
        if (wr_ctrl && sel_i[0])
            nxt_ctrl = dat_i[2:0];
        if (wr && adr_i == `AEF_ADR_ERRLIM)
            nxt_errlim = wmerge(errlim_ff, dat_i, sel_i);
        if (wr && adr_i == `AEF_ADR_CMDPOS)
            nxt_cmdpos = wmerge(cmdpos_ff, dat_i, sel_i);
        if (wr && adr_i == `AEF_ADR_HSEL && sel_i[0])
            nxt_hsel = dat_i[6:0];
        if (wr && adr_i == `AEF_ADR_IRQMSK && sel_i[0])
            nxt_mask = dat_i[2:0];
        if (wr && adr_i == `AEF_ADR_WDLIM)
            nxt_wdlim = wmerge(wdlim_ff, dat_i, sel_i);
        // A new event wins over the clear of its own read
        nxt_stat = (rd_irqst ? 3'h0 : stat_ff) | events;
    end

    // Counter, amplifier and phase state
    always_comb
    begin
        nxt_pos = pos_ff;
        if (mode == AEF_QUAD)
        begin
            // Both channels moving at once is a lost step, not a count
            if (a_edge != b_edge)
                nxt_pos = (a_now ^ b_old) ? 32'(pos_ff + 32'h1)
                                          : 32'(pos_ff - 32'h1);
        end
        else if (a_now && !a_old)
            nxt_pos = b_now ? 32'(pos_ff + 32'h1) : 32'(pos_ff - 32'h1);
        if (wr_pos)
            nxt_pos = wmerge(pos_ff, dat_i, sel_i);
        nxt_wdcnt = wdcnt_ff;
        if (kick || !wd_on)
            nxt_wdcnt = 32'h0;
        else if (!wd_exp)
            nxt_wdcnt = 32'(wdcnt_ff + 32'h1);
        // Disable sources outrank a motor-on in the same cycle
        nxt_amp_on = amp_on_ff;
        if (moff_cmd || wd_trip || wd_exp || err_trip)
            nxt_amp_on = 1'b0;
        else if (mon_cmd)
            nxt_amp_on = 1'b1;
        nxt_amp_out = nxt_amp_on ^ nxt_ctrl[`AEF_CTRL_AMPINV];
        nxt_phase    = phase_ff;
        nxt_phase_ok = phase_ok_ff;
        if (wr && adr_i == `AEF_ADR_PHASE && sel_i[0])
        begin
            nxt_phase    = dat_i[2:0];
            nxt_phase_ok = 1'b1;
        end
        else if (!phase_ok_ff && hsel_ok && sector != `AEF_HALL_BAD)
        begin
            nxt_phase    = sector;
            nxt_phase_ok = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        enc_s1_ff   <= {index_i, quad_channel_b_i, quad_channel_a_i};
        enc_s2_ff   <= enc_s1_ff;
        din_s1_ff   <= dig_in_i;
        din_s2_ff   <= din_s1_ff;
        enc_prev_ff <= enc_s2_ff;
        dat_ff      <= nxt_dat;
        if (rst_i)
        begin
            ctrl_ff     <= 3'h0;
            errlim_ff   <= `AEF_ERRLIM_RST;
            cmdpos_ff   <= 32'h0;
            pos_ff      <= 32'h0;
            hsel_ff     <= `AEF_HSEL_RST;
            wdlim_ff    <= `AEF_WDLIM_RST;
            wdcnt_ff    <= 32'h0;
            amp_on_ff   <= 1'b0;
            amp_out_ff  <= 1'b0;
            stat_ff     <= 3'h0;
            mask_ff     <= 3'h0;
            phase_ff    <= 3'h0;
            phase_ok_ff <= 1'b0;
            ack_ff      <= 1'b0;
        end
        else
        begin
            ctrl_ff     <= nxt_ctrl;
            errlim_ff   <= nxt_errlim;
            cmdpos_ff   <= nxt_cmdpos;
            pos_ff      <= nxt_pos;
            hsel_ff     <= nxt_hsel;
            wdlim_ff    <= nxt_wdlim;
            wdcnt_ff    <= nxt_wdcnt;
            amp_on_ff   <= nxt_amp_on;
            amp_out_ff  <= nxt_amp_out;
            stat_ff     <= nxt_stat;
            mask_ff     <= nxt_mask;
            phase_ff    <= nxt_phase;
            phase_ok_ff <= nxt_phase_ok;
            ack_ff      <= nxt_ack;
        end
    end

    assign ack_o            = ack_ff;
    assign dat_o            = dat_ff;
    assign amp_enable_out_o = amp_out_ff;
    assign irq_o            = |(stat_ff & mask_ff);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    wd_drop_amp_a: assert property (wd_trip |=> !amp_on_ff)
        else $error("amp stayed on after watchdog trip");
    mo_drop_amp_a: assert property (moff_cmd |=> !amp_on_ff)
        else $error("amp stayed on after motor off");
    err_drop_amp_a: assert property (
        ctrl_ff[`AEF_CTRL_OOE] && amp_on_ff && over |=> !amp_on_ff)
        else $error("amp stayed on with excess error");
    amp_level_a: assert property (
        !ctrl_ff[`AEF_CTRL_AMPINV] && !$past(ctrl_ff[`AEF_CTRL_AMPINV])
        && !$past(rst_i) |-> amp_enable_out_o == amp_on_ff)
        else $error("amp enable level does not follow state");
    quad_step_a: assert property (
        mode == AEF_QUAD && !wr_pos |=>
        (pos_ff == $past(pos_ff)) || (pos_ff == 32'($past(pos_ff) + 1)) ||
        (pos_ff == 32'($past(pos_ff) - 1)))
        else $error("quadrature count jumped");
    quad_count_a: assert property (
        mode == AEF_QUAD && !wr_pos && a_edge && !b_edge |=>
        pos_ff != $past(pos_ff))
        else $error("single channel edge not counted");
    step_dir_a: assert property (
        mode == AEF_STEPDIR && !wr_pos && a_now && !a_old && b_now |=>
        pos_ff == 32'($past(pos_ff) + 1))
        else $error("step pulse not counted up");
    hall_phase_a: assert property (
        !phase_ok_ff && hsel_ok && sector != `AEF_HALL_BAD && !wr |=>
        phase_ok_ff && phase_ff == $past(sector))
        else $error("hall phase not captured");
    bus_ack_a: assert property (acc |=> ack_o ##1 !ack_o)
        else $error("bus ack not a single cycle");
endmodule

// ===== aef_enc_model.sv
// Encoder, index and Hall sensor model for one axis
module aef_enc_model (
    // Clock
    input  wire logic        clk_i,
    // Sensor lines
    output logic             quad_channel_a_o,
    output logic             quad_channel_b_o,
    output logic             index_o,
    output logic [95:0]      dig_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph;

    initial
    begin
        ph = 2'h0;
        quad_channel_a_o = 1'b0;
        quad_channel_b_o = 1'b0;
        index_o = 1'b0;
        dig_in_o = '0;
    end

    // Four cycles per edge clears the three-stage sync and compare path
    task automatic quad_move(input int n, input logic up);
        repeat (n)
        begin
            ph = up ? ph + 2'h1 : ph - 2'h1;
            @(posedge clk_i);
            quad_channel_a_o <= ph[1] ^ ph[0];
            quad_channel_b_o <= ph[1];
            repeat (4) @(posedge clk_i);
        end
    endtask

    // A alone moves; B is held to expose any double count
    task automatic toggle_a();
        @(posedge clk_i);
        quad_channel_a_o <= ~quad_channel_a_o;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic step_dir(input int n, input logic up);
        @(posedge clk_i);
        quad_channel_b_o <= up;
        repeat (n)
        begin
            @(posedge clk_i);
            quad_channel_a_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            quad_channel_a_o <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask

    task automatic hall(input int start, input logic [2:0] code);
        @(posedge clk_i);
        dig_in_o <= 96'(code) << (start - 1);
    endtask

    task automatic index_pulse();
        @(posedge clk_i);
        index_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        index_o <= 1'b0;
    endtask
endmodule

// ===== aef_axis_tb_top.sv
// Self-checking bench for the axis enable and feedback block
`include "aef_cfg.svh"
module aef_axis_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aef_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, amp_enable_out_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    aef_word_t dat_i, dat_o, q;
    logic qa, qb, idx;
    logic [95:0] dig;
    int failures, num_checks;
    int st[8] = '{1, 6, 17, 78, 81, 94, 7, 79};

    aef_enc_model i_aef_enc_model (.clk_i(clk_i), .quad_channel_a_o(qa),
        .quad_channel_b_o(qb), .index_o(idx), .dig_in_o(dig));
    aef_axis i_aef_axis (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
        .quad_channel_a_i(qa), .quad_channel_b_i(qb), .index_i(idx),
        .dig_in_i(dig), .amp_enable_out_o(amp_enable_out_o), .irq_o(irq_o));

    task automatic chk_w(input string nm, input aef_word_t e, aef_word_t g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_b(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask

    // Holds the request until ack is seen at an edge, never a fixed wait
    task automatic wb(input logic w, logic [7:0] a, aef_word_t d);
        @(posedge clk_i);
        chk_b("ack_idle", 1'b0, ack_o);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, logic [7:0] a, aef_word_t e);
        wb(1'b0, a, '0);
        chk_w(nm, e, q);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic t_reset();
        chk_b("amp", 1'b0, amp_enable_out_o);
        chk_b("irq", 1'b0, irq_o);
        rd_chk("errlim", `AEF_ADR_ERRLIM, 32'h000007d0);
        wb(1'b0, `AEF_ADR_STATUS, '0);
        chk_b("phok", 1'b0, q[11]);
        wb(1'b1, 8'h40, 32'h0000ffff);
        rd_chk("unmapped", 8'h40, 32'h00000000);
        wb(1'b1, `AEF_ADR_ERRLIM, 32'h00000003);
        rd_chk("errlim", `AEF_ADR_ERRLIM, 32'h00000003);
    endtask

    task automatic t_amp();
        wb(1'b1, `AEF_ADR_CMD, 32'h00000002);
        wt(2);
        chk_b("amp", 1'b1, amp_enable_out_o);
        wb(1'b1, `AEF_ADR_CTRL, 32'h00000004);
        wt(2);
        chk_b("amp", 1'b0, amp_enable_out_o);
        wb(1'b1, `AEF_ADR_CTRL, 32'h00000000);
        wb(1'b1, `AEF_ADR_CMD, 32'h00000003);
        wt(2);
        chk_b("amp", 1'b0, amp_enable_out_o);
    endtask

    task automatic t_encoder();
        wb(1'b1, `AEF_ADR_POS, '0);
        i_aef_enc_model.quad_move(5, 1'b1);
        rd_chk("pos", `AEF_ADR_POS, 32'h00000005);
        i_aef_enc_model.quad_move(2, 1'b0);
        rd_chk("pos", `AEF_ADR_POS, 32'h00000003);
        i_aef_enc_model.toggle_a();
        rd_chk("pos", `AEF_ADR_POS, 32'h00000002);
        i_aef_enc_model.toggle_a();
        rd_chk("pos", `AEF_ADR_POS, 32'h00000003);
        wb(1'b1, `AEF_ADR_CTRL, 32'h00000002);
        wb(1'b1, `AEF_ADR_POS, 32'h0000000a);
        i_aef_enc_model.step_dir(3, 1'b1);
        rd_chk("pos", `AEF_ADR_POS, 32'h0000000d);
        i_aef_enc_model.step_dir(1, 1'b0);
        rd_chk("pos", `AEF_ADR_POS, 32'h0000000c);
        wb(1'b1, `AEF_ADR_CTRL, 32'h00000000);
    endtask

    task automatic t_ooe();
        wb(1'b0, `AEF_ADR_IRQST, '0);
        wb(1'b1, `AEF_ADR_POS, '0);
        wb(1'b1, `AEF_ADR_CMDPOS, 32'hfffffffd);
        wb(1'b1, `AEF_ADR_IRQMSK, 32'h00000002);
        wb(1'b1, `AEF_ADR_CTRL, 32'h00000001);
        wb(1'b1, `AEF_ADR_CMD, 32'h00000002);
        wt(3);
        chk_b("amp", 1'b1, amp_enable_out_o);
        chk_b("irq", 1'b0, irq_o);
        wb(1'b1, `AEF_ADR_CMDPOS, 32'h00000004);
        wt(3);
        chk_b("amp", 1'b0, amp_enable_out_o);
        chk_b("irq", 1'b1, irq_o);
        rd_chk("irqst", `AEF_ADR_IRQST, 32'h00000002);
        chk_b("irq", 1'b0, irq_o);
        wb(1'b1, `AEF_ADR_CTRL, 32'h00000000);
    endtask

    task automatic t_wdog();
        wb(1'b1, `AEF_ADR_IRQMSK, 32'h00000001);
        wb(1'b1, `AEF_ADR_WDLIM, 32'h00000010);
        wb(1'b1, `AEF_ADR_CMD, 32'h00000002);
        wt(6);
        wb(1'b1, `AEF_ADR_CMD, 32'h00000004);
        wt(8);
        chk_b("amp", 1'b1, amp_enable_out_o);
        wt(20);
        chk_b("amp", 1'b0, amp_enable_out_o);
        chk_b("irq", 1'b1, irq_o);
        rd_chk("irqst", `AEF_ADR_IRQST, 32'h00000001);
        wb(1'b1, `AEF_ADR_WDLIM, '0);
    endtask

    task automatic t_index_hall();
        wb(1'b1, `AEF_ADR_IRQMSK, 32'h00000004);
        i_aef_enc_model.index_pulse();
        wt(4);
        chk_b("irq", 1'b1, irq_o);
        rd_chk("irqst", `AEF_ADR_IRQST, 32'h00000004);
        chk_b("irq", 1'b0, irq_o);
        // Code 5 reads the same in either line order
        for (int i = 0; i < 8; i++)
        begin
            i_aef_enc_model.hall(st[i], 3'h5);
            wb(1'b1, `AEF_ADR_HSEL, 32'(st[i]));
            wt(4);
            wb(1'b0, `AEF_ADR_STATUS, '0);
            chk_b("hsel_ok", i < 6, q[12]);
            if (i < 6)
                chk_w("hall", 32'h00000005, 32'(q[6:4]));
        end
        chk_b("phok", 1'b1, q[11]);
        chk_w("phase", 32'h00000005, 32'(q[10:8]));
        wb(1'b1, `AEF_ADR_PHASE, 32'h00000002);
        rd_chk("phase", `AEF_ADR_PHASE, 32'h00000002);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial
    begin
        wt(6000);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        {rst_i, cyc_i, stb_i, we_i} = 4'h8;
        adr_i = '0;
        sel_i = 4'hf;
        dat_i = '0;
        failures = 0;
        num_checks = 0;
        wt(10);
        rst_i <= 1'b0;
        t_reset();
        t_amp();
        t_encoder();
        t_ooe();
        t_wdog();
        t_index_hall();
        tally_and_finish();
    end
endmodule
